/* File: rtl/dcp_pkg.sv */
// Shared constants and types for the DDR4 command and data pin block.
// Assumes a link clock from the controller and a separate system clock.
//
// Contract
// - Every address and control pin is captured on the rising link clock edge.
// - Clock enable high runs the device; low enters power-down or self refresh.
// - Self-refresh exit follows clock enable alone; other inputs are ignored meanwhile.
// - Commands with chip select high are ignored; chip select gates the code and is not part of it.
// - Termination input high enables nominal termination unless it is disabled.
// - Activate low with chip select decodes activate; strobe pins are row bits (here only write enable is taken, as row bit 14).
// - With activate high the strobe pins and write enable form the command code.
// - Write beats whose mask pin samples low are discarded, on both strobe edges.
// - With inversion enabled, a low inversion pin means the data is inverted.
// - Mask or inversion use follows mode register five; strobe use mode register one.
// - Group select picks the group; low group bit and bank pick the mode register.
// - Bank select picks the bank inside the group for bank commands.
// - Read or write with the auto close bit high closes the bank after the burst.
// - Precharge with the auto close bit high closes all banks, else one.
// - Storage is sixteen banks in four groups of four.
// - Bursts are eight beats, or four beats when chopped.
// - Read latency is programmable from 10 to 20 clocks.
// - Write latency is 9, 10, 11, 12, 14, 16 or 18 clocks.
// - Commands on each rising edge; data moves as two beats per clock.
// - The read strobe preamble is one or two clocks.
// - With on-the-fly chopping, a low burst chop bit chops the burst.
// - Reset is active low and asynchronous.
// - Row address bits 0 to 14 are taken at activate.
package dcp_pkg;
  localparam int unsigned NUM_BANKS = 16;
  localparam int unsigned LINE_BEATS = 8;
  localparam logic [1:0] LAST_CLK_FULL = 2'h3;
  localparam logic [1:0] LAST_CLK_CHOP = 2'h1;
  localparam logic [4:0] RL_RESET = 5'h0a;
  localparam logic [4:0] WL_RESET = 5'h09;
  localparam logic [4:0] PRE_ONE_CNT = 5'h02;
  localparam logic [4:0] PRE_TWO_CNT = 5'h03;
  localparam int unsigned AUTO_CLOSE_BIT = 10;
  localparam int unsigned BURST_CHOP_BIT = 12;
  localparam int unsigned MR5_MASK = 0;
  localparam int unsigned MR5_WINV = 1;
  localparam int unsigned MR5_RINV = 2;
  localparam logic [1:0] BM_FIXED8 = 2'h0;
  localparam logic [1:0] BM_OTF = 2'h1;
  localparam logic [1:0] BM_FIXED4 = 2'h2;
  localparam logic [2:0] CODE_MRS = 3'h0;
  localparam logic [2:0] CODE_REF = 3'h1;
  localparam logic [2:0] CODE_PRE = 3'h2;
  localparam logic [2:0] CODE_WR = 3'h4;
  localparam logic [2:0] CODE_RD = 3'h5;
  localparam logic [2:0] CODE_NOP = 3'h7;
  localparam int unsigned CFG_W = 18;
  localparam int unsigned STAT_W = 3;
  localparam logic [CFG_W-1:0] CFG_RESET = 18'h0;
  typedef enum logic [1:0] {
    PS_ACTIVE   = 2'h0,
    PS_PRE_PD   = 2'h1,
    PS_SELF_REF = 2'h3,
    PS_ACT_PD   = 2'h2
  } dcp_pstate_t;
  typedef enum logic [1:0] {
    XF_IDLE = 2'h0,
    XF_WAIT = 2'h1,
    XF_DATA = 2'h3
  } dcp_xfer_t;
  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_ACT  = 3'h1,
    CMD_RD   = 3'h2,
    CMD_WR   = 3'h3,
    CMD_PRE  = 3'h4,
    CMD_REF  = 3'h5,
    CMD_MRS  = 3'h6,
    CMD_OTH  = 3'h7
  } dcp_cmd_t;
endpackage

/* File: rtl/dcp_sync_if.sv */
// Interface carrying a bundle of levels across a clock boundary.
// Assumes the source holds each level steady long enough to be seen.
`timescale 1ns/1ps
`default_nettype none
interface dcp_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] stable;
  modport src (output raw);
  modport sync (input raw, output stable);
  modport dst (input stable);
endinterface
`default_nettype wire

/* File: rtl/dcp_sync.sv */
// Three-stage level synchroniser with an agreement filter.
// Assumes the source side changes a bundle only while the far side is idle.
`timescale 1ns/1ps
`default_nettype none
module dcp_sync #(parameter int W = 1) (
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  dcp_sync_if.sync  sif
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] out_ff;
  logic [W-1:0] nxt_out;

  // A bit moves only once the second and third stages agree.
  always_comb
  begin
    nxt_out = (~(s2_ff ^ s3_ff) & s2_ff) | ((s2_ff ^ s3_ff) & out_ff);
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      s1_ff  <= '0;
      s2_ff  <= '0;
      s3_ff  <= '0;
      out_ff <= '0;
    end
    else
    begin
      s1_ff  <= sif.raw;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      out_ff <= nxt_out;
    end
  end

  assign sif.stable = out_ff;
endmodule
`default_nettype wire

/* File: rtl/dcp_top.sv */
// Device-side command, address and data pin logic of a DDR4 memory.
// Assumes pins are driven on the link clock; configuration comes from the system clock.
`timescale 1ns/1ps
`default_nettype none
module dcp_top (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_ck_link,
  input  wire logic        i_cke,
  input  wire logic        i_cs_n,
  input  wire logic        i_activate_n,
  input  wire logic        i_row_strobe_n,
  input  wire logic        i_col_strobe_n,
  input  wire logic        i_write_enable_n,
  input  wire logic [1:0]  i_group_select,
  input  wire logic [1:0]  i_bank_select,
  input  wire logic [13:0] i_addr,
  input  wire logic        i_termination_ctrl,
  input  wire logic [7:0]  i_wdata_rise,
  input  wire logic [7:0]  i_wdata_fall,
  input  wire logic        i_write_mask_rise,
  input  wire logic        i_write_mask_fall,
  input  wire logic        i_nominal_termination_en,
  input  wire logic        i_mode_reg_one_termination_strobe,
  input  wire logic [2:0]  i_mode_reg_five_mask_inv,
  input  wire logic        i_preamble_two,
  input  wire logic [1:0]  i_burst_mode,
  input  wire logic [4:0]  i_read_latency,
  input  wire logic [4:0]  i_write_latency,
  output logic             o_clk_run,
  output logic             o_term_en,
  output logic             o_termination_strobe,
  output logic             o_cmd_vld,
  output logic [2:0]       o_cmd,
  output logic [3:0]       o_cmd_bank,
  output logic [14:0]      o_cmd_addr,
  output logic [2:0]       o_mode_sel,
  output logic [15:0]      o_open_banks,
  output logic [7:0]       o_dq_rise,
  output logic [7:0]       o_dq_fall,
  output logic             o_dq_oe,
  output logic             o_bus_inversion_rise,
  output logic             o_bus_inversion_fall,
  output logic             o_bus_inversion_oe,
  output logic             o_dqs_oe,
  output logic [1:0]       o_power_state,
  output logic             o_in_buf_en
);
  dcp_sync_if #(.W(dcp_pkg::CFG_W))  u_cfg_if ();
  dcp_sync_if #(.W(dcp_pkg::STAT_W)) u_stat_if ();

  logic        cfg_rtt, cfg_termination_strobe, cfg_mask, cfg_winv, cfg_rinv, cfg_pre2;
  logic [1:0]  cfg_bm;
  logic [4:0]  cfg_rl, cfg_wl;
  dcp_pkg::dcp_pstate_t pstate_ff, nxt_pstate;
  dcp_pkg::dcp_xfer_t   xfer_ff, nxt_xfer;
  dcp_pkg::dcp_cmd_t    dec, cmd_ff;
  logic [15:0] open_ff, nxt_open;
  logic [4:0]  cnt_ff, nxt_cnt;
  logic [1:0]  beat_ff, nxt_beat, cur_beat;
  logic        is_rd_ff, nxt_is_rd, chop_ff, nxt_chop, ap_ff, nxt_ap;
  logic [3:0]  xbank_ff, nxt_xbank, bank_idx;
  logic [7:0]  mem_ff [dcp_pkg::NUM_BANKS][dcp_pkg::LINE_BEATS];
  logic [7:0]  nxt_mem [dcp_pkg::NUM_BANKS][dcp_pkg::LINE_BEATS];
  logic [7:0]  dq_r_ff, dq_f_ff, nxt_dq_r, nxt_dq_f, rd_r, rd_f;
  logic        dq_oe_ff, nxt_dq_oe, inv_r_ff, inv_f_ff, nxt_inv_r, nxt_inv_f;
  logic        inv_oe_ff, dqs_ff, nxt_dqs, term_ff, nxt_term, tstr_ff, clk_run_ff;
  logic        cmd_vld_ff, cmd_ok, sre, start, go, last, mask_on, winv_on, rinv_on;
  logic [3:0]  cbank_ff;
  logic [14:0] caddr_ff;
  logic [2:0]  msel_ff, code;
  logic [1:0]  ps_sys_ff;
  logic        inbuf_ff, nxt_inbuf;

  // Configuration levels cross into the link domain; change them only while idle.
  assign u_cfg_if.raw = {i_write_latency, i_read_latency, i_burst_mode, i_preamble_two,
                         i_mode_reg_five_mask_inv, i_mode_reg_one_termination_strobe,
                         i_nominal_termination_en};
  assign {cfg_wl, cfg_rl, cfg_bm, cfg_pre2, cfg_rinv, cfg_winv, cfg_mask, cfg_termination_strobe,
          cfg_rtt} = u_cfg_if.stable;

  dcp_sync #(.W(dcp_pkg::CFG_W)) u_cfg_sync (
    .i_clk   (i_ck_link),
    .i_rst_b (i_rst_b),
    .sif     (u_cfg_if)
  );

  function automatic logic [7:0] store_beat(input logic [7:0] old, input logic [7:0] d,
                                            input logic pin, input logic mon,
                                            input logic ion);
    logic [7:0] res;
    res = d;
    if (mon && !pin)
      res = old;
    else if (ion && !pin)
      res = ~d;
    return res;
  endfunction

  function automatic logic many_zeros(input logic [7:0] d);
    logic [3:0] z;
    z = 4'h0;
    for (int i = 0; i < 8; i++)
      z = z + {3'h0, ~d[i]};
    return z > 4'h4;
  endfunction

  // Shared pin roles: termination strobe takes the pin from mask and inversion.
  assign mask_on = cfg_mask && !cfg_termination_strobe;
  assign winv_on = cfg_winv && !cfg_mask && !cfg_termination_strobe;
  assign rinv_on = cfg_rinv && !cfg_termination_strobe;

  // Pins are decoded at the rising link edge; chip select high masks all commands.
  assign code     = {i_row_strobe_n, i_col_strobe_n, i_write_enable_n};
  assign cmd_ok   = i_cke && (pstate_ff == dcp_pkg::PS_ACTIVE) && !i_cs_n;
  assign sre      = !i_cke && !i_cs_n && i_activate_n && (code == dcp_pkg::CODE_REF);
  assign bank_idx = {i_group_select, i_bank_select};

  always_comb
  begin
    dec = dcp_pkg::CMD_NONE;
    if (cmd_ok && !i_activate_n)
      dec = dcp_pkg::CMD_ACT;
    else if (cmd_ok)
    begin
      case (code)
        dcp_pkg::CODE_MRS: dec = dcp_pkg::CMD_MRS;
        dcp_pkg::CODE_REF: dec = dcp_pkg::CMD_REF;
        dcp_pkg::CODE_PRE: dec = dcp_pkg::CMD_PRE;
        dcp_pkg::CODE_WR:  dec = dcp_pkg::CMD_WR;
        dcp_pkg::CODE_RD:  dec = dcp_pkg::CMD_RD;
        dcp_pkg::CODE_NOP: dec = dcp_pkg::CMD_NONE;
        default:           dec = dcp_pkg::CMD_OTH;
      endcase
    end
  end

  always_comb
  begin
    nxt_pstate = pstate_ff;
    case (pstate_ff)
      dcp_pkg::PS_ACTIVE:
      begin
        if (!i_cke && sre)
          nxt_pstate = dcp_pkg::PS_SELF_REF;
        else if (!i_cke && (open_ff != 16'h0))
          nxt_pstate = dcp_pkg::PS_ACT_PD;
        else if (!i_cke)
          nxt_pstate = dcp_pkg::PS_PRE_PD;
      end
      dcp_pkg::PS_PRE_PD, dcp_pkg::PS_ACT_PD, dcp_pkg::PS_SELF_REF:
      begin
        if (i_cke)
          nxt_pstate = dcp_pkg::PS_ACTIVE;
      end
      default: nxt_pstate = dcp_pkg::PS_ACTIVE;
    endcase
  end

  // One burst runs at a time; a read or write during a burst is not started.
  assign start    = ((dec == dcp_pkg::CMD_RD) || (dec == dcp_pkg::CMD_WR)) &&
                    (xfer_ff == dcp_pkg::XF_IDLE);
  assign go       = ((xfer_ff == dcp_pkg::XF_WAIT) && (cnt_ff == 5'h01)) ||
                    (xfer_ff == dcp_pkg::XF_DATA);
  assign cur_beat = (xfer_ff == dcp_pkg::XF_DATA) ? beat_ff : 2'h0;
  assign last     = cur_beat == (chop_ff ? dcp_pkg::LAST_CLK_CHOP : dcp_pkg::LAST_CLK_FULL);
  assign rd_r     = mem_ff[xbank_ff][{cur_beat, 1'b0}];
  assign rd_f     = mem_ff[xbank_ff][{cur_beat, 1'b1}];

  always_comb
  begin
    nxt_xfer  = xfer_ff;
    nxt_cnt   = cnt_ff;
    nxt_beat  = beat_ff;
    nxt_is_rd = is_rd_ff;
    nxt_chop  = chop_ff;
    nxt_ap    = ap_ff;
    nxt_xbank = xbank_ff;
    nxt_open  = open_ff;
    nxt_mem   = mem_ff;
    nxt_dq_r  = dq_r_ff;
    nxt_dq_f  = dq_f_ff;
    nxt_dq_oe = 1'b0;
    nxt_inv_r = 1'b1;
    nxt_inv_f = 1'b1;
    if ((dec == dcp_pkg::CMD_PRE) && i_addr[dcp_pkg::AUTO_CLOSE_BIT])
      nxt_open = 16'h0;
    else if (dec == dcp_pkg::CMD_PRE)
      nxt_open[bank_idx] = 1'b0;
    case (xfer_ff)
      dcp_pkg::XF_IDLE:
      begin
        if (start)
        begin
          nxt_xfer  = dcp_pkg::XF_WAIT;
          nxt_is_rd = dec == dcp_pkg::CMD_RD;
          nxt_cnt   = (dec == dcp_pkg::CMD_RD) ? cfg_rl : cfg_wl;
          nxt_chop  = (cfg_bm == dcp_pkg::BM_FIXED4) || ((cfg_bm == dcp_pkg::BM_OTF) &&
                      !i_addr[dcp_pkg::BURST_CHOP_BIT]);
          nxt_ap    = i_addr[dcp_pkg::AUTO_CLOSE_BIT];
          nxt_xbank = bank_idx;
        end
      end
      dcp_pkg::XF_WAIT:
      begin
        nxt_cnt = cnt_ff - 5'h01;
        if (cnt_ff == 5'h01)
          nxt_xfer = dcp_pkg::XF_DATA;
      end
      dcp_pkg::XF_DATA: nxt_xfer = dcp_pkg::XF_DATA;
      default: nxt_xfer = dcp_pkg::XF_IDLE;
    endcase
    // Each link clock moves a rising-edge beat and a falling-edge beat.
    if (go)
    begin
      nxt_beat = cur_beat + 2'h1;
      if (is_rd_ff)
      begin
        nxt_inv_r = !(rinv_on && many_zeros(rd_r));
        nxt_inv_f = !(rinv_on && many_zeros(rd_f));
        nxt_dq_r  = nxt_inv_r ? rd_r : ~rd_r;
        nxt_dq_f  = nxt_inv_f ? rd_f : ~rd_f;
        nxt_dq_oe = 1'b1;
      end
      else
      begin
        nxt_mem[xbank_ff][{cur_beat, 1'b0}] = store_beat(rd_r, i_wdata_rise,
          i_write_mask_rise, mask_on, winv_on);
        nxt_mem[xbank_ff][{cur_beat, 1'b1}] = store_beat(rd_f, i_wdata_fall,
          i_write_mask_fall, mask_on, winv_on);
      end
      if (last)
      begin
        nxt_xfer = dcp_pkg::XF_IDLE;
        nxt_beat = 2'h0;
        if (ap_ff)
          nxt_open[xbank_ff] = 1'b0;
      end
    end
    // An activate is applied last, so its set wins over a closing burst.
    if (dec == dcp_pkg::CMD_ACT)
      nxt_open[bank_idx] = 1'b1;
  end

  // The strobe opens one or two clocks before the first read beat.
  always_comb
  begin
    nxt_dqs = is_rd_ff && (go || ((xfer_ff == dcp_pkg::XF_WAIT) &&
              (cnt_ff <= (cfg_pre2 ? dcp_pkg::PRE_TWO_CNT : dcp_pkg::PRE_ONE_CNT))));
    nxt_term = i_termination_ctrl && cfg_rtt && (pstate_ff != dcp_pkg::PS_SELF_REF);
  end

  always_ff @(posedge i_ck_link or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      pstate_ff  <= dcp_pkg::PS_ACTIVE;
      xfer_ff    <= dcp_pkg::XF_IDLE;
      cnt_ff     <= 5'h00;
      beat_ff    <= 2'h0;
      is_rd_ff   <= 1'b0;
      chop_ff    <= 1'b0;
      ap_ff      <= 1'b0;
      xbank_ff   <= 4'h0;
      open_ff    <= 16'h0;
      mem_ff     <= '{default: '{default: 8'h00}};
      dq_r_ff    <= 8'h00;
      dq_f_ff    <= 8'h00;
      dq_oe_ff   <= 1'b0;
      inv_r_ff   <= 1'b1;
      inv_f_ff   <= 1'b1;
      inv_oe_ff  <= 1'b0;
      dqs_ff     <= 1'b0;
      term_ff    <= 1'b0;
      tstr_ff    <= 1'b0;
      clk_run_ff <= 1'b0;
      cmd_vld_ff <= 1'b0;
      cmd_ff     <= dcp_pkg::CMD_NONE;
      cbank_ff   <= 4'h0;
      caddr_ff   <= 15'h0000;
      msel_ff    <= 3'h0;
    end
    else
    begin
      pstate_ff  <= nxt_pstate;
      xfer_ff    <= nxt_xfer;
      cnt_ff     <= nxt_cnt;
      beat_ff    <= nxt_beat;
      is_rd_ff   <= nxt_is_rd;
      chop_ff    <= nxt_chop;
      ap_ff      <= nxt_ap;
      xbank_ff   <= nxt_xbank;
      open_ff    <= nxt_open;
      mem_ff     <= nxt_mem;
      dq_r_ff    <= nxt_dq_r;
      dq_f_ff    <= nxt_dq_f;
      dq_oe_ff   <= nxt_dq_oe;
      inv_r_ff   <= nxt_inv_r;
      inv_f_ff   <= nxt_inv_f;
      inv_oe_ff  <= nxt_dq_oe && rinv_on;
      dqs_ff     <= nxt_dqs;
      term_ff    <= nxt_term;
      tstr_ff    <= nxt_term && cfg_termination_strobe;
      clk_run_ff <= i_cke;
      cmd_vld_ff <= dec != dcp_pkg::CMD_NONE;
      cmd_ff     <= dec;
      cbank_ff   <= bank_idx;
      caddr_ff   <= {i_write_enable_n, i_addr};
      msel_ff    <= {i_group_select[0], i_bank_select};
    end
  end

  // Self-refresh exit is seen here from clock enable alone, even with no link clock.
  assign u_stat_if.raw = {i_cke, pstate_ff};

  dcp_sync #(.W(dcp_pkg::STAT_W)) u_stat_sync (
    .i_clk   (i_sys_clk),
    .i_rst_b (i_rst_b),
    .sif     (u_stat_if)
  );

  always_comb
  begin
    nxt_inbuf = !((u_stat_if.stable[1:0] == dcp_pkg::PS_SELF_REF) &&
                  !u_stat_if.stable[2]);
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ps_sys_ff <= dcp_pkg::PS_ACTIVE;
      inbuf_ff  <= 1'b1;
    end
    else
    begin
      ps_sys_ff <= u_stat_if.stable[1:0];
      inbuf_ff  <= nxt_inbuf;
    end
  end

  assign o_clk_run            = clk_run_ff;
  assign o_term_en            = term_ff;
  assign o_termination_strobe = tstr_ff;
  assign o_cmd_vld            = cmd_vld_ff;
  assign o_cmd                = cmd_ff;
  assign o_cmd_bank           = cbank_ff;
  assign o_cmd_addr           = caddr_ff;
  assign o_mode_sel           = msel_ff;
  assign o_open_banks         = open_ff;
  assign o_dq_rise            = dq_r_ff;
  assign o_dq_fall            = dq_f_ff;
  assign o_dq_oe              = dq_oe_ff;
  assign o_bus_inversion_rise = inv_r_ff;
  assign o_bus_inversion_fall = inv_f_ff;
  assign o_bus_inversion_oe   = inv_oe_ff;
  assign o_dqs_oe             = dqs_ff;
  assign o_power_state        = ps_sys_ff;
  assign o_in_buf_en          = inbuf_ff;

  // Cycles since the last accepted burst command, read only by the checks below.
  logic [5:0] cyc_ff;
  always_ff @(posedge i_ck_link or negedge i_rst_b)
  begin
    if (!i_rst_b)
      cyc_ff <= 6'h00;
    else if (start)
      cyc_ff <= 6'h00;
    else if (cyc_ff != 6'h3f)
      cyc_ff <= cyc_ff + 6'h01;
  end

  property p_cs_mask;
    @(posedge i_ck_link) disable iff (!i_rst_b) i_cs_n |=> !o_cmd_vld;
  endproperty
  a_cs_mask: assert property (p_cs_mask) else $error("command taken with select high");

  property p_act_row;
    @(posedge i_ck_link) disable iff (!i_rst_b)
      (cmd_ok && !i_activate_n) |=> (o_cmd == dcp_pkg::CMD_ACT) &&
      (o_cmd_addr[14] == $past(i_write_enable_n)) && o_open_banks[o_cmd_bank];
  endproperty
  a_act_row: assert property (p_act_row) else $error("activate decode wrong");

  property p_term_off;
    @(posedge i_ck_link) disable iff (!i_rst_b)
      (!cfg_rtt || !i_termination_ctrl) |=> !o_term_en;
  endproperty
  a_term_off: assert property (p_term_off) else $error("termination on while disabled");

  property p_pre_all;
    @(posedge i_ck_link) disable iff (!i_rst_b)
      ((dec == dcp_pkg::CMD_PRE) && i_addr[10] && !go) |=> (o_open_banks == 16'h0);
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("precharge all left a bank open");

  property p_rd_lat;
    @(posedge i_ck_link) disable iff (!i_rst_b)
      $rose(o_dq_oe) |-> (cyc_ff == {1'b0, cfg_rl});
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read data at wrong latency");

  property p_wr_lat;
    @(posedge i_ck_link) disable iff (!i_rst_b)
      (go && !is_rd_ff && (xfer_ff == dcp_pkg::XF_WAIT)) |-> (cyc_ff + 6'h01 == {1'b0, cfg_wl});
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write data at wrong latency");

  property p_preamble;
    @(posedge i_ck_link) disable iff (!i_rst_b)
      $rose(o_dq_oe) |-> $past(o_dqs_oe) && ($past(o_dqs_oe, 2) == cfg_pre2);
  endproperty
  a_preamble: assert property (p_preamble) else $error("strobe preamble length wrong");

  property p_chop;
    @(posedge i_ck_link) disable iff (!i_rst_b)
      ($fell(o_dq_oe) && $past(chop_ff)) |-> $past(o_dq_oe, 2) && !$past(o_dq_oe, 3);
  endproperty
  a_chop: assert property (p_chop) else $error("chopped read not two clocks");

  property p_masked;
    @(posedge i_ck_link) disable iff (!i_rst_b)
      (go && !is_rd_ff && mask_on && !i_write_mask_rise) |=>
      (mem_ff[$past(xbank_ff)][{$past(cur_beat), 1'b0}] == $past(rd_r));
  endproperty
  a_masked: assert property (p_masked) else $error("masked beat was stored");

  property p_selfref;
    @(posedge i_ck_link) disable iff (!i_rst_b)
      (pstate_ff == dcp_pkg::PS_SELF_REF) |=> !o_cmd_vld;
  endproperty
  a_selfref: assert property (p_selfref) else $error("command taken in self refresh");

  property p_mode_sel;
    @(posedge i_ck_link) disable iff (!i_rst_b)
      (dec == dcp_pkg::CMD_MRS) |=> o_mode_sel == $past({i_group_select[0], i_bank_select});
  endproperty
  a_mode_sel: assert property (p_mode_sel) else $error("mode register select wrong");

  property p_cov_rd;
    @(posedge i_ck_link) disable iff (!i_rst_b) o_dq_oe && !o_bus_inversion_rise;
  endproperty
  c_cov_rd: cover property (p_cov_rd);
  property p_cov_sr;
    @(posedge i_ck_link) disable iff (!i_rst_b) pstate_ff == dcp_pkg::PS_SELF_REF;
  endproperty
  c_cov_sr: cover property (p_cov_sr);
  property p_cov_ap;
    @(posedge i_ck_link) disable iff (!i_rst_b) go && last && ap_ff;
  endproperty
  c_cov_ap: cover property (p_cov_ap);
endmodule
`default_nettype wire

/* File: tb/dcp_ctl_model.sv */
// Controller model driving command pins, clock enable and write beats.
// Assumes the bench makes the free-running link clock.
`timescale 1ns/1ps
`default_nettype none
module dcp_ctl_model (
  input  wire logic        i_ck,
  output logic             o_cke,
  output logic             o_cs_n,
  output logic [3:0]       o_code,
  output logic [3:0]       o_bank,
  output logic [13:0]      o_addr,
  output logic [7:0]       o_wr_rise,
  output logic [7:0]       o_wr_fall
);
  initial
  begin
    o_cke = 1'h1;
    o_cs_n = 1'h1;
    o_code = 4'hf;
    o_bank = 4'h0;
    o_addr = 14'h0;
    o_wr_rise = 8'h5a;
    o_wr_fall = 8'ha5;
  end
  // Pins change just after an edge and hold through the next sampling edge.
  task automatic send(input logic cs, input logic [3:0] code, input logic [3:0] bank,
                      input logic [13:0] addr);
    @(posedge i_ck);
    #1;
    o_cs_n = cs;
    o_code = code;
    o_bank = bank;
    o_addr = addr;
    @(posedge i_ck);
    #1;
    o_cs_n = 1'h1;
    o_code = 4'hf;
    o_addr = ~addr;
  endtask
  // Beat pairs follow the write after the programmed latency, then are scrambled.
  task automatic wbeats(input int lat, input logic [7:0] base);
    repeat (lat - 1) @(posedge i_ck);
    for (int k = 0; k < 4; k++)
    begin
      #1;
      o_wr_rise = base + 8'(2 * k);
      o_wr_fall = base + 8'(2 * k + 1);
      @(posedge i_ck);
    end
    #1;
    o_wr_rise = ~o_wr_rise;
    o_wr_fall = ~o_wr_fall;
  endtask
  task automatic power(input logic lvl);
    @(posedge i_ck);
    #1;
    o_cke = lvl;
  endtask
endmodule
`default_nettype wire

/* File: tb/dcp_top_tb_top.sv */
// Self-checking bench for the DDR4 command and data pin block.
// Assumes the controller model drives the command, clock enable and write data pins; the bench drives termination and mask.
`timescale 1ns/1ps
`default_nettype none
module dcp_top_tb_top;
  logic        sys_clk, ck, rst_b, cs_n, cke, vld, dq_oe, clk_run, term_en;
  logic [3:0]  code, bank, cbank;
  logic [13:0] addr;
  logic [7:0]  wr_r, wr_f, dq_r, dq_f;
  logic [2:0]  cmd, msel;
  logic [15:0] open_b;
  logic [1:0]  pst, bmode;
  logic        term, wm_r, wm_f, tstr, inv_r, inv_f, inv_oe, dqs, inbuf;
  logic [2:0]  minv;
  logic [14:0] caddr;
  int          fail_count = 0;
  int          check_count = 0;
  dcp_ctl_model i_dcp_ctl_model (.i_ck(ck), .o_cke(cke), .o_cs_n(cs_n), .o_code(code),
    .o_bank(bank), .o_addr(addr), .o_wr_rise(wr_r), .o_wr_fall(wr_f));
  // Mask pin high keeps every beat and means no inversion.
  dcp_top i_dcp_top (.i_sys_clk(sys_clk), .i_rst_b(rst_b), .i_ck_link(ck), .i_cke(cke),
    .i_cs_n(cs_n), .i_activate_n(code[3]), .i_row_strobe_n(code[2]),
    .i_col_strobe_n(code[1]), .i_write_enable_n(code[0]), .i_group_select(bank[3:2]),
    .i_bank_select(bank[1:0]), .i_addr(addr), .i_termination_ctrl(term),
    .i_wdata_rise(wr_r), .i_wdata_fall(wr_f), .i_write_mask_rise(wm_r),
    .i_write_mask_fall(wm_f), .i_nominal_termination_en(1'h1), .i_mode_reg_one_termination_strobe(1'h0),
    .i_mode_reg_five_mask_inv(minv), .i_preamble_two(1'h0), .i_burst_mode(bmode),
    .i_read_latency(5'h0a), .i_write_latency(5'h09), .o_clk_run(clk_run),
    .o_term_en(term_en), .o_termination_strobe(tstr), .o_cmd_vld(vld), .o_cmd(cmd),
    .o_cmd_bank(cbank), .o_cmd_addr(caddr), .o_mode_sel(msel), .o_open_banks(open_b),
    .o_dq_rise(dq_r), .o_dq_fall(dq_f), .o_dq_oe(dq_oe), .o_bus_inversion_rise(inv_r),
    .o_bus_inversion_fall(inv_f), .o_bus_inversion_oe(inv_oe), .o_dqs_oe(dqs),
    .o_power_state(pst), .o_in_buf_en(inbuf));
  initial
  begin
    sys_clk = 1'h0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial
  begin
    ck = 1'h0;
    #7;
    forever #32 ck = ~ck;
  end
  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    fail_count++;
    conclude();
  end
  initial
  begin
    rst_b = 1'h0;
    term = 1'h1;
    wm_r = 1'h1;
    wm_f = 1'h1;
    minv = 3'h0;
    bmode = 2'h0;
    repeat (8) @(posedge sys_clk);
    #1 rst_b = 1'h1;
    repeat (8) @(posedge ck);
    #1;
    chk({term_en, tstr}, 2'h2);
    term = 1'h0;
    @(posedge ck);
    #1;
    chk(term_en, 1'h0);
    term = 1'h1;
    i_dcp_ctl_model.send(1'h0, 4'h7, 4'h5, 14'h0123);
    chk({vld, cmd, cbank}, {1'h1, 3'h1, 4'h5});
    chk(caddr, 15'h4123);
    i_dcp_ctl_model.send(1'h1, 4'h7, 4'h6, 14'h0123);
    chk({vld, open_b}, {1'h0, 16'h0020});
    i_dcp_ctl_model.send(1'h0, 4'h8, 4'h6, 14'h0000);
    chk(msel, 3'h6);
    $display("test commands done");
    i_dcp_ctl_model.send(1'h0, 4'hc, 4'h5, 14'h0000);
    chk(cmd, 3'h3);
    i_dcp_ctl_model.wbeats(9, 8'h10);
    minv = 3'h1;
    wm_r = 1'h0;
    i_dcp_ctl_model.send(1'h0, 4'hc, 4'h5, 14'h0000);
    i_dcp_ctl_model.wbeats(9, 8'h30);
    i_dcp_ctl_model.send(1'h0, 4'hd, 4'h5, 14'h0400);
    chk(cmd, 3'h2);
    repeat (9) @(posedge ck);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge ck);
      #1;
      chk({dq_oe, dq_r, dq_f}, {1'h1, 8'h10 + 8'(2 * k), 8'h31 + 8'(2 * k)});
    end
    @(posedge ck);
    #1;
    chk({dq_oe, open_b}, {1'h0, 16'h0000});
    $display("test burst done");
    minv = 3'h4;
    bmode = 2'h1;
    repeat (4) @(posedge ck);
    i_dcp_ctl_model.send(1'h0, 4'hd, 4'h5, 14'h0000);
    repeat (10) @(posedge ck);
    #1;
    chk({dq_oe, dq_r, dq_f}, {1'h1, 8'hef, 8'hce});
    chk({inv_r, inv_f, inv_oe, dqs}, 4'h3);
    @(posedge ck);
    #1;
    chk({dq_oe, dq_r, dq_f}, {1'h1, 8'hed, 8'h33});
    chk({inv_r, inv_f, inv_oe, dqs}, 4'h7);
    @(posedge ck);
    #1;
    chk({dq_oe, dqs}, 2'h0);
    $display("test inversion done");
    i_dcp_ctl_model.send(1'h0, 4'h7, 4'h9, 14'h0000);
    i_dcp_ctl_model.send(1'h0, 4'h7, 4'h3, 14'h0000);
    chk(open_b, 16'h0208);
    i_dcp_ctl_model.send(1'h0, 4'ha, 4'h9, 14'h0000);
    chk(open_b, 16'h0008);
    i_dcp_ctl_model.send(1'h0, 4'ha, 4'h0, 14'h0400);
    chk(open_b, 16'h0000);
    i_dcp_ctl_model.send(1'h0, 4'h9, 4'h0, 14'h0000);
    chk(cmd, 3'h5);
    $display("test precharge done");
    i_dcp_ctl_model.power(1'h0);
    repeat (12) @(posedge sys_clk);
    chk({clk_run, pst}, {1'h0, 2'h1});
    i_dcp_ctl_model.power(1'h1);
    repeat (12) @(posedge sys_clk);
    chk({clk_run, pst}, {1'h1, 2'h0});
    $display("test power done");
    fork
      i_dcp_ctl_model.power(1'h0);
      i_dcp_ctl_model.send(1'h0, 4'h9, 4'h0, 14'h0000);
    join
    i_dcp_ctl_model.send(1'h0, 4'h7, 4'h2, 14'h0000);
    chk(vld, 1'h0);
    repeat (12) @(posedge sys_clk);
    chk({clk_run, pst, inbuf}, {1'h0, 2'h3, 1'h0});
    i_dcp_ctl_model.power(1'h1);
    repeat (12) @(posedge sys_clk);
    chk({pst, inbuf}, 3'h1);
    $display("test self refresh done");
    conclude();
  end
endmodule
`default_nettype wire
